// ---- rtl/acr_pkg.sv ----
// Package with the register map, field positions and constants of the configuration bank.
package acr_pkg;
   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [5:0] ACR_CHAIN_IDENTITY = 6'h00;
   localparam logic [5:0] ACR_RESET_POWER_CONTROL = 6'h04;
   localparam logic [5:0] ACR_INPUT_PROTOCOL_CONTROL = 6'h08;
   localparam logic [5:0] ACR_OUTPUT_PROTOCOL_CONTROL = 6'h0c;
   localparam logic [5:0] ACR_OUTPUT_WORD_CONTROL = 6'h10;
   localparam logic [5:0] ACR_INPUT_RANGE_SELECT = 6'h14;
   localparam logic [5:0] ACR_ALARM_FLAGS = 6'h20;
   localparam logic [5:0] ACR_ALARM_HIGH_THRESHOLD = 6'h24;
   localparam logic [5:0] ACR_ALARM_LOW_THRESHOLD = 6'h28;
   localparam logic [5:0] ACR_KEY_BYTE = 6'h05;
   localparam logic [5:0] ACR_CHAIN_BYTE = 6'h02;
   localparam logic [5:0] ACR_OUT_CTL_HI_BYTE = 6'h0d;
   // ----------------------------------------------------------------
   // Field positions and values
   // ----------------------------------------------------------------
   localparam logic [7:0] ACR_UNLOCK_KEY = 8'h69;
   localparam logic [7:0] ACR_KEY_RESET = 8'h00;
   localparam logic [3:0] ACR_CHAIN_RESET = 4'h0;
   localparam int ACR_SUPPLY_ALARM_DISABLE_BIT = 5;
   localparam int ACR_INPUT_ALARM_DISABLE_BIT = 4;
   localparam int ACR_RESET_PIN_CLASS_BIT = 2;
   localparam int ACR_LIGHT_SLEEP_ENABLE_BIT = 1;
   localparam int ACR_POWER_DOWN_BIT = 0;
   localparam int ACR_SOURCE_CLOCK_SELECT_BIT = 6;
   localparam int ACR_GPO_VALUE_HI_BIT = 4;
   localparam logic [1:0] ACR_PIN_TRISTATE = 2'h0;
   localparam logic [1:0] ACR_PIN_ALARM = 2'h1;
   localparam logic [1:0] ACR_PIN_GPO = 2'h2;
   localparam logic [1:0] ACR_PIN_DUAL = 2'h3;
   localparam logic [1:0] ACR_OUT_MODE_SPI = 2'h0;
   // ----------------------------------------------------------------
   // Shifting and clocks
   // ----------------------------------------------------------------
   localparam int ACR_WORD_BITS = 32;
   localparam logic [5:0] ACR_CYCLES_SINGLE = 6'h20;
   localparam logic [5:0] ACR_CYCLES_DUAL = 6'h10;
   localparam logic [3:0] ACR_INT_DIV = 4'h4;
   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic en;
      logic [5:0] addr;
      logic [7:0] data;
   } acr_wr_s;
   typedef enum logic [1:0] {
      ACR_IDLE = 2'b01,
      ACR_SHIFT = 2'b10
   } acr_state_e;
endpackage : acr_pkg

// ---- rtl/acr_regs.sv ----
// Configuration register bank with source-synchronous read-out of the converter.
//
// Contract
// RQ1 - Strobe pin carries output clock in source mode.
// RQ2 - Strobe clock from serial clock or internal.
// RQ3 - One data line; config 11b adds second.
// RQ4 - Same edge timing; dual needs half cycles.
// RQ5 - Nine word registers of four byte slots.
// RQ6 - Bytes consecutive, low byte at base.
// RQ7 - Chain position bits 19-16, reset zero.
// RQ8 - Reserved bits read back as zeros.
// RQ9 - Host writes key 69h before power writes.
// RQ10 - Bits 5-0 writable only with key 69h.
// RQ11 - Bit 5 disables supply alarm.
// RQ12 - Bit 4 disables input alarm.
// RQ13 - Bit 2 picks full or application pin reset.
// RQ14 - Application reset class holds until power cycle.
// RQ15 - Light sleep when enabled and select high.
// RQ16 - Bit 0 requests power-down.
// RQ17 - Class and sleep bits survive application reset.
// RQ18 - Bit 6 picks serial or internal clock.
// RQ19 - Pin config: tristate, alarm, output, dual.
// RQ20 - Register writes accepted while powered down.
`timescale 1ns/10ps
`default_nettype none
module acr_regs (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic reset_pin_n_i,
   input wire acr_pkg::acr_wr_s wr_i,
   input wire logic rd_en_i,
   input wire logic [5:0] rd_addr_i,
   output logic [7:0] rd_data_o,
   output logic rd_valid_o,
   input wire logic sclk_i,
   input wire logic convert_start_select_i,
   input wire logic conversion_done_i,
   input wire logic supply_alarm_i,
   input wire logic input_alarm_i,
   input wire logic start_i,
   input wire logic [31:0] word_i,
   output logic busy_o,
   output logic ready_strobe_pin_o,
   output logic first_serial_output_o,
   output logic shared_alarm_output_pin_o,
   output logic shared_alarm_output_pin_oe_o,
   output logic power_down_o,
   output logic light_sleep_state_o,
   output logic [1:0] input_protocol_mode_o
);
   import acr_pkg::*;

   // ----------------------------------------------------------------
   // Synchronisers and reset classes
   // ----------------------------------------------------------------
   logic [1:0] rpin_ff;
   logic [1:0] sclk_sync_ff;
   logic [1:0] css_ff;
   logic sclk_prev_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rpin_ff <= 2'h3;
         sclk_sync_ff <= 2'h0;
         css_ff <= 2'h0;
         sclk_prev_ff <= 1'b0;
      end else begin
         rpin_ff <= {rpin_ff[0], reset_pin_n_i};
         sclk_sync_ff <= {sclk_sync_ff[0], sclk_i};
         css_ff <= {css_ff[0], convert_start_select_i};
         sclk_prev_ff <= sclk_sync_ff[1];
      end
   end

   logic class_ff;
   logic light_sleep_enable_ff;
   logic full_clr;
   logic app_clr;
   assign full_clr = rst_i | (~rpin_ff[1] & ~class_ff); // RQ13
   assign app_clr = ~rpin_ff[1] & class_ff; // RQ13

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [3:0] chain_ff;
   logic [7:0] key_ff;
   logic sup_dis_ff;
   logic in_dis_ff;
   logic pd_ff;
   logic [1:0] in_mode_ff;
   logic [1:0] out_mode_ff;
   logic src_sel_ff;
   logic [1:0] pin_cfg_ff;
   logic gpo_ff;
   logic [7:0] gen_ff [16];
   logic key_ok;
   logic pw_wr;
   assign key_ok = (key_ff == ACR_UNLOCK_KEY);
   // Writes are never gated by the power-down request.
   assign pw_wr = wr_i.en && (wr_i.addr == ACR_RESET_POWER_CONTROL) && key_ok; // RQ20 RQ10

   always_ff @(posedge clk_i) begin
      if (full_clr || app_clr) begin
         chain_ff <= ACR_CHAIN_RESET; // RQ7
         key_ff <= ACR_KEY_RESET; // RQ10
         sup_dis_ff <= 1'b0; // RQ11
         in_dis_ff <= 1'b0; // RQ12
         pd_ff <= 1'b0; // RQ16
         in_mode_ff <= 2'h0;
         out_mode_ff <= ACR_OUT_MODE_SPI;
         src_sel_ff <= 1'b0;
         pin_cfg_ff <= ACR_PIN_TRISTATE;
         gpo_ff <= 1'b0;
      end else if (wr_i.en) begin
         case (wr_i.addr) // RQ6
            ACR_CHAIN_BYTE: begin
               chain_ff <= wr_i.data[3:0]; // RQ7
            end
            ACR_KEY_BYTE: begin
               key_ff <= wr_i.data; // RQ9
            end
            ACR_RESET_POWER_CONTROL: begin
               if (key_ok) begin // RQ10
                  sup_dis_ff <= wr_i.data[ACR_SUPPLY_ALARM_DISABLE_BIT]; // RQ11
                  in_dis_ff <= wr_i.data[ACR_INPUT_ALARM_DISABLE_BIT]; // RQ12
                  pd_ff <= wr_i.data[ACR_POWER_DOWN_BIT]; // RQ16
               end
            end
            ACR_INPUT_PROTOCOL_CONTROL: begin
               in_mode_ff <= wr_i.data[1:0];
            end
            ACR_OUTPUT_PROTOCOL_CONTROL: begin
               out_mode_ff <= wr_i.data[1:0];
               src_sel_ff <= wr_i.data[ACR_SOURCE_CLOCK_SELECT_BIT]; // RQ18
            end
            ACR_OUT_CTL_HI_BYTE: begin
               pin_cfg_ff <= wr_i.data[1:0]; // RQ19
               gpo_ff <= wr_i.data[ACR_GPO_VALUE_HI_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   // Power-on-only fields: only a full-class clear touches them.
   always_ff @(posedge clk_i) begin
      if (full_clr) begin
         class_ff <= 1'b0; // RQ17
         light_sleep_enable_ff <= 1'b0; // RQ17
      end else if (pw_wr) begin
         class_ff <= class_ff | wr_i.data[ACR_RESET_PIN_CLASS_BIT]; // RQ14
         light_sleep_enable_ff <= wr_i.data[ACR_LIGHT_SLEEP_ENABLE_BIT]; // RQ15
      end
   end

   // Output word, range and threshold registers hold whole bytes.
   logic gen_hit;
   logic [3:0] gen_idx;
   always_comb begin
      gen_hit = 1'b0;
      gen_idx = {2'h0, wr_i.addr[1:0]};
      case (wr_i.addr[5:2])
         4'h4: begin
            gen_hit = 1'b1;
            gen_idx = {2'h0, wr_i.addr[1:0]};
         end
         4'h5: begin
            gen_hit = 1'b1;
            gen_idx = {2'h1, wr_i.addr[1:0]};
         end
         4'h9: begin
            gen_hit = 1'b1;
            gen_idx = {2'h2, wr_i.addr[1:0]};
         end
         4'ha: begin
            gen_hit = 1'b1;
            gen_idx = {2'h3, wr_i.addr[1:0]};
         end
         default: begin
         end
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (full_clr || app_clr) begin
         for (int i = 0; i < 16; i++) begin
            gen_ff[i] <= 8'h00;
         end
      end else if (wr_i.en && gen_hit) begin
         gen_ff[gen_idx] <= wr_i.data; // RQ5
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   logic [7:0] nxt_rd;
   always_comb begin
      nxt_rd = 8'h00; // RQ8
      case (rd_addr_i)
         ACR_CHAIN_BYTE: nxt_rd = {4'h0, chain_ff}; // RQ7
         ACR_KEY_BYTE: nxt_rd = key_ff;
         ACR_RESET_POWER_CONTROL: nxt_rd = {2'h0, sup_dis_ff, in_dis_ff, 1'b0,
                                            class_ff, light_sleep_enable_ff, pd_ff}; // RQ8
         ACR_INPUT_PROTOCOL_CONTROL: nxt_rd = {6'h00, in_mode_ff};
         ACR_OUTPUT_PROTOCOL_CONTROL: nxt_rd = {1'b0, src_sel_ff, 4'h0, out_mode_ff};
         ACR_OUT_CTL_HI_BYTE: nxt_rd = {3'h0, gpo_ff, 2'h0, pin_cfg_ff};
         ACR_ALARM_FLAGS: nxt_rd = {6'h00, input_alarm_i, supply_alarm_i};
         default: begin
            case (rd_addr_i[5:2])
               4'h4: nxt_rd = gen_ff[{2'h0, rd_addr_i[1:0]}];
               4'h5: nxt_rd = gen_ff[{2'h1, rd_addr_i[1:0]}];
               4'h9: nxt_rd = gen_ff[{2'h2, rd_addr_i[1:0]}];
               4'ha: nxt_rd = gen_ff[{2'h3, rd_addr_i[1:0]}];
               default: nxt_rd = 8'h00;
            endcase
         end
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_data_o <= 8'h00;
         rd_valid_o <= 1'b0;
      end else begin
         rd_data_o <= rd_en_i ? nxt_rd : 8'h00;
         rd_valid_o <= rd_en_i;
      end
   end

   // ----------------------------------------------------------------
   // Power and light sleep
   // ----------------------------------------------------------------
   assign power_down_o = pd_ff; // RQ16
   assign input_protocol_mode_o = in_mode_ff;
   always_ff @(posedge clk_i) begin
      if (full_clr || !light_sleep_enable_ff || !css_ff[1]
          || (pw_wr && !wr_i.data[ACR_LIGHT_SLEEP_ENABLE_BIT])) begin
         light_sleep_state_o <= 1'b0; // RQ15
      end else if (conversion_done_i) begin
         light_sleep_state_o <= 1'b1; // RQ15
      end
   end

   // ----------------------------------------------------------------
   // Source-synchronous shifter
   // ----------------------------------------------------------------
   logic [3:0] div_ff;
   logic int_tick;
   logic tick;
   logic dual;
   logic src_mode;
   assign int_tick = (div_ff == ACR_INT_DIV - 4'h1);
   assign tick = src_sel_ff ? int_tick : (sclk_sync_ff[1] & ~sclk_prev_ff); // RQ2 RQ18
   assign dual = (pin_cfg_ff == ACR_PIN_DUAL); // RQ3
   assign src_mode = (out_mode_ff != ACR_OUT_MODE_SPI);
   always_ff @(posedge clk_i) begin
      if (rst_i || int_tick) begin
         div_ff <= 4'h0;
      end else begin
         div_ff <= div_ff + 4'h1;
      end
   end

   acr_state_e state_ff;
   logic [31:0] sh_ff;
   logic [5:0] cnt_ff;
   logic dual_ff;
   always_ff @(posedge clk_i) begin
      if (full_clr || app_clr) begin
         state_ff <= ACR_IDLE;
         sh_ff <= 32'h0;
         cnt_ff <= 6'h0;
         dual_ff <= 1'b0;
         ready_strobe_pin_o <= 1'b0;
      end else begin
         case (state_ff)
            ACR_IDLE: begin
               ready_strobe_pin_o <= 1'b0;
               if (start_i && src_mode) begin
                  state_ff <= ACR_SHIFT;
                  sh_ff <= word_i;
                  dual_ff <= dual;
                  cnt_ff <= dual ? ACR_CYCLES_DUAL : ACR_CYCLES_SINGLE; // RQ4
               end
            end
            ACR_SHIFT: begin
               if (tick) begin
                  ready_strobe_pin_o <= ~ready_strobe_pin_o; // RQ1
                  if (ready_strobe_pin_o) begin
                     cnt_ff <= cnt_ff - 6'h1;
                     sh_ff <= dual_ff ? {sh_ff[29:0], 2'h0} : {sh_ff[30:0], 1'b0}; // RQ4
                     if (cnt_ff == 6'h1) begin
                        state_ff <= ACR_IDLE;
                     end
                  end
               end
            end
            default: begin
               state_ff <= ACR_IDLE;
            end
         endcase
      end
   end
   assign busy_o = (state_ff == ACR_SHIFT);
   assign first_serial_output_o = sh_ff[ACR_WORD_BITS - 1]; // RQ1

   // ----------------------------------------------------------------
   // Shared alarm pin
   // ----------------------------------------------------------------
   logic alarm;
   logic pin_ff;
   assign alarm = (supply_alarm_i & ~sup_dis_ff) | (input_alarm_i & ~in_dis_ff); // RQ11 RQ12
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_ff <= 1'b0;
         shared_alarm_output_pin_oe_o <= 1'b0;
      end else begin
         shared_alarm_output_pin_oe_o <= (pin_cfg_ff != ACR_PIN_TRISTATE); // RQ19
         case (pin_cfg_ff) // RQ19
            ACR_PIN_ALARM: pin_ff <= alarm;
            ACR_PIN_GPO: pin_ff <= gpo_ff;
            default: pin_ff <= 1'b0;
         endcase
      end
   end
   // Dual data comes straight from the shifter so both lines change on the same edge.
   assign shared_alarm_output_pin_o = (pin_cfg_ff == ACR_PIN_DUAL) ?
                                      sh_ff[ACR_WORD_BITS - 2] : pin_ff; // RQ3 RQ4

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_strobe_idle_low: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
      (state_ff == ACR_IDLE) |=> !ready_strobe_pin_o || busy_o)
      else $error("strobe active while idle");
   a_key_gate_write: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
      wr_i.en && wr_i.addr == ACR_RESET_POWER_CONTROL && !key_ok && !app_clr && !full_clr
      |=> $stable(pd_ff) && $stable(sup_dis_ff) && $stable(in_dis_ff))
      else $error("power control written without key");
   a_class_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // RQ14
      class_ff |=> class_ff)
      else $error("reset pin class dropped");
   a_nap_keeps_app: assert property (@(posedge clk_i) disable iff (rst_i) // RQ17
      app_clr && light_sleep_enable_ff |=> light_sleep_enable_ff)
      else $error("sleep enable lost on application reset");
   a_dual_half_len: assert property (@(posedge clk_i) disable iff (full_clr || app_clr) // RQ4
      $rose(busy_o) |-> cnt_ff == (($past(pin_cfg_ff) == ACR_PIN_DUAL) ? ACR_CYCLES_DUAL
      : ACR_CYCLES_SINGLE))
      else $error("wrong cycle count at load");
   a_pin_tristate: assert property (@(posedge clk_i) disable iff (rst_i) // RQ19
      pin_cfg_ff == ACR_PIN_TRISTATE |=> !shared_alarm_output_pin_oe_o)
      else $error("shared pin driven in tristate");
   a_alarm_gated: assert property (@(posedge clk_i) disable iff (rst_i) // RQ11
      pin_cfg_ff == ACR_PIN_ALARM && !(wr_i.en && wr_i.addr == ACR_OUT_CTL_HI_BYTE)
      |=> shared_alarm_output_pin_o == ($past(supply_alarm_i && !sup_dis_ff)
      || $past(input_alarm_i && !in_dis_ff)))
      else $error("alarm pin does not follow enabled alarms");
   a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
      rd_en_i && rd_addr_i == 6'h03 |=> rd_data_o == 8'h00)
      else $error("reserved byte read nonzero");
   a_sleep_needs_en: assert property (@(posedge clk_i) disable iff (rst_i) // RQ15
      light_sleep_state_o |-> light_sleep_enable_ff)
      else $error("light sleep without enable");
   a_chain_read: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
      rd_en_i && rd_addr_i == ACR_CHAIN_BYTE |=> rd_data_o[3:0] == $past(chain_ff))
      else $error("chain position read mismatch");
endmodule : acr_regs
`default_nettype wire

// ---- tb/acr_host_model.sv ----
// Host model: serial clock source and capture of the source-synchronous read-out.
`timescale 1ns/10ps
`default_nettype none
module acr_host_model (
   input wire logic run_i,
   input wire logic dual_i,
   input wire logic clr_i,
   input wire logic strobe_i,
   input wire logic d0_i,
   input wire logic d1_i,
   output logic sclk_o,
   output logic [31:0] word_o,
   output logic [5:0] edges_o
);
   // ----------------------------------------------------------------
   // Serial clock, still outside frames
   // ----------------------------------------------------------------
   initial begin
      sclk_o = 1'b0;
      #7;
      forever begin
         #100;
         sclk_o = run_i ? ~sclk_o : 1'b0;
      end
   end
   // ----------------------------------------------------------------
   // Capture on the rising strobe edge, two bits a period in dual mode
   // ----------------------------------------------------------------
   always @(posedge strobe_i or posedge clr_i) begin
      if (clr_i) begin
         word_o <= 32'h0000_0000;
         edges_o <= 6'h00;
      end else begin
         edges_o <= edges_o + 6'h01;
         if (dual_i) begin
            word_o <= {word_o[29:0], d0_i, d1_i};
         end else begin
            word_o <= {word_o[30:0], d0_i};
         end
      end
   end
endmodule : acr_host_model
`default_nettype wire

// ---- tb/test_acr_regs.sv ----
// Self-checking testbench for the configuration register bank.
`timescale 1ns/10ps
`default_nettype none
module test_acr_regs;
   import acr_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic reset_pin_n_i = 1'b1;
   acr_wr_s wr_i = '0;
   logic rd_en_i = 1'b0;
   logic [5:0] rd_addr_i = 6'h00;
   logic cs_sel = 1'b0, done = 1'b0, sup_al = 1'b0, in_al = 1'b0, start_i = 1'b0;
   logic [31:0] word_i = 32'h0000_0000;
   logic run = 1'b0, dual = 1'b0, clr = 1'b0;
   logic [7:0] rd_data_o;
   logic rd_valid_o, busy_o, strobe, d0, pin, pin_oe, pwr_dn, ls_state, sclk;
   logic [1:0] ipm;
   logic [31:0] got;
   logic [5:0] edges;
   int failures = 0;
   int n_checks = 0;
   always #12.5 clk_i = ~clk_i;
   acr_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .reset_pin_n_i(reset_pin_n_i), .wr_i(wr_i),
      .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
      .sclk_i(sclk), .convert_start_select_i(cs_sel), .conversion_done_i(done),
      .supply_alarm_i(sup_al), .input_alarm_i(in_al), .start_i(start_i), .word_i(word_i),
      .busy_o(busy_o), .ready_strobe_pin_o(strobe), .first_serial_output_o(d0),
      .shared_alarm_output_pin_o(pin), .shared_alarm_output_pin_oe_o(pin_oe),
      .power_down_o(pwr_dn), .light_sleep_state_o(ls_state), .input_protocol_mode_o(ipm));
   acr_host_model host (.run_i(run), .dual_i(dual), .clr_i(clr), .strobe_i(strobe), .d0_i(d0),
      .d1_i(pin_oe ? pin : ~d0), .sclk_o(sclk), .word_o(got), .edges_o(edges));
   // ----------------------------------------------------------------
   // Reporting and comparison
   // ----------------------------------------------------------------
   task automatic fail(input string msg);
      failures++;
      $display("ERROR at %0t ns: %s", $time, msg);
   endtask : fail
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) fail($sformatf("byte %h expected %h", g, e));
   endtask : chk_byte
   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) fail($sformatf("word %h expected %h", g, e));
   endtask : chk_word
   task automatic chk_bit(input logic g, input logic e);
      n_checks++;
      if (g !== e) fail($sformatf("bit %b expected %b", g, e));
   endtask : chk_bit
   task automatic give_verdict;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict
   // ----------------------------------------------------------------
   // Register port access
   // ----------------------------------------------------------------
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge clk_i);
      wr_i = '{en: 1'b1, addr: a, data: d};
      @(negedge clk_i);
      wr_i = '0;
   endtask : wr
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
      int k;
      @(negedge clk_i);
      rd_en_i = 1'b1;
      rd_addr_i = a;
      @(negedge clk_i);
      rd_en_i = 1'b0;
      k = 0;
      while (rd_valid_o !== 1'b1 && k < 3) begin
         @(negedge clk_i);
         k++;
      end
      if (rd_valid_o !== 1'b1) fail("no read answer");
      chk_byte(rd_data_o, e);
   endtask : rd_chk
   task automatic pin_reset;
      reset_pin_n_i = 1'b0;
      repeat (4) @(negedge clk_i);
      reset_pin_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
   endtask : pin_reset
   task automatic wait_ls(input logic v);
      int k;
      k = 0;
      while (ls_state !== v && k < 10) begin
         @(negedge clk_i);
         k++;
      end
      chk_bit(ls_state, v);
   endtask : wait_ls
   task automatic shift(input logic [31:0] w, input logic dl, input logic ext, input logic [5:0] n);
      int k;
      @(negedge clk_i);
      clr = 1'b1;
      dual = dl;
      word_i = w;
      start_i = 1'b1;
      @(negedge clk_i);
      clr = 1'b0;
      start_i = 1'b0;
      run = ext;
      chk_bit(busy_o, 1'b1);
      k = 0;
      while (busy_o === 1'b1 && k < 4000) begin
         @(negedge clk_i);
         k++;
      end
      run = 1'b0;
      chk_word(got, w);
      chk_byte({2'b00, edges}, {2'b00, n});
   endtask : shift
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      rd_chk(ACR_CHAIN_BYTE, 8'h00);
      rd_chk(ACR_KEY_BYTE, 8'h00);
      rd_chk(ACR_RESET_POWER_CONTROL, 8'h00);
      wr(ACR_CHAIN_BYTE, 8'hff);
      rd_chk(ACR_CHAIN_BYTE, 8'h0f);
      wr(6'h03, 8'hff);
      rd_chk(6'h03, 8'h00);
      wr(6'h18, 8'h5a);
      rd_chk(6'h18, 8'h00);
      wr(ACR_INPUT_PROTOCOL_CONTROL, 8'hfe);
      rd_chk(ACR_INPUT_PROTOCOL_CONTROL, 8'h02);
      chk_byte({6'h00, ipm}, 8'h02);
      for (int i = 0; i < 4; i++) begin
         wr(ACR_OUTPUT_WORD_CONTROL + 6'(i), 8'(8'h11 * (i + 1)));
      end
      for (int i = 0; i < 4; i++) begin
         rd_chk(ACR_OUTPUT_WORD_CONTROL + 6'(i), 8'(8'h11 * (i + 1)));
      end
      $display("test map done");
      wr(ACR_RESET_POWER_CONTROL, 8'h37);
      rd_chk(ACR_RESET_POWER_CONTROL, 8'h00);
      chk_bit(pwr_dn, 1'b0);
      wr(ACR_KEY_BYTE, ACR_UNLOCK_KEY);
      rd_chk(ACR_KEY_BYTE, 8'h69);
      wr(ACR_RESET_POWER_CONTROL, 8'hff);
      rd_chk(ACR_RESET_POWER_CONTROL, 8'h37);
      chk_bit(pwr_dn, 1'b1);
      wr(ACR_INPUT_RANGE_SELECT, 8'ha5);
      rd_chk(ACR_INPUT_RANGE_SELECT, 8'ha5);
      wr(ACR_RESET_POWER_CONTROL, 8'h32);
      rd_chk(ACR_RESET_POWER_CONTROL, 8'h36);
      chk_bit(pwr_dn, 1'b0);
      $display("test key done");
      pin_reset();
      rd_chk(ACR_RESET_POWER_CONTROL, 8'h06);
      rd_chk(ACR_KEY_BYTE, 8'h00);
      rd_chk(ACR_OUTPUT_WORD_CONTROL, 8'h00);
      cs_sel = 1'b1;
      repeat (3) @(negedge clk_i);
      done = 1'b1;
      @(negedge clk_i);
      done = 1'b0;
      wait_ls(1'b1);
      cs_sel = 1'b0;
      wait_ls(1'b0);
      rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      rd_chk(ACR_RESET_POWER_CONTROL, 8'h00);
      wr(ACR_KEY_BYTE, ACR_UNLOCK_KEY);
      wr(ACR_RESET_POWER_CONTROL, 8'h02);
      pin_reset();
      rd_chk(ACR_RESET_POWER_CONTROL, 8'h00);
      $display("test resets done");
      wr(ACR_OUT_CTL_HI_BYTE, 8'h12);
      @(negedge clk_i);
      chk_bit(pin_oe, 1'b1);
      chk_bit(pin, 1'b1);
      wr(ACR_OUT_CTL_HI_BYTE, 8'h00);
      @(negedge clk_i);
      chk_bit(pin_oe, 1'b0);
      wr(ACR_OUT_CTL_HI_BYTE, 8'h01);
      sup_al = 1'b1;
      @(negedge clk_i);
      chk_bit(pin_oe, 1'b1);
      chk_bit(pin, 1'b1);
      rd_chk(ACR_ALARM_FLAGS, 8'h01);
      sup_al = 1'b0;
      wr(ACR_OUT_CTL_HI_BYTE, 8'h00);
      start_i = 1'b1;
      @(negedge clk_i);
      start_i = 1'b0;
      @(negedge clk_i);
      chk_bit(busy_o, 1'b0);
      $display("test pins done");
      wr(ACR_OUTPUT_PROTOCOL_CONTROL, 8'h01);
      shift(32'ha5c3_1e69, 1'b0, 1'b1, 6'h20);
      wr(ACR_OUTPUT_PROTOCOL_CONTROL, 8'h41);
      shift(32'h5a3c_e187, 1'b0, 1'b0, 6'h20);
      wr(ACR_OUT_CTL_HI_BYTE, 8'h03);
      shift(32'h3c5a_96f0, 1'b1, 1'b0, 6'h10);
      wr(ACR_OUTPUT_PROTOCOL_CONTROL, 8'h01);
      shift(32'hc3a5_0f96, 1'b1, 1'b1, 6'h10);
      $display("test shift done");
      give_verdict();
   end
   initial begin
      #2000000;
      failures++;
      $display("ERROR at %0t ns: watchdog expired", $time);
      give_verdict();
   end
endmodule : test_acr_regs
`default_nettype wire
